// >>> design/lasp_port.sv
// Bus host port of the link adaptor: four registers, flags and interrupts.
// Assumes the host pins are synchronous to ref_clk and the link transmitter
// and receiver sit outside, signalling with one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "lasp_cfg.svh"

// Functional notes
// - Data present set on receive, cleared by read
// - Interrupt enable bits writable and readable
// - Receive irq equals enable and data present
// - Output data write sends packet
// - Output data read undefined, no effect
// - Output ready: empty and acked; reset high
// - Transmit irq equals enable and ready
// - Input data read lowers receive irq
// - Output data write lowers transmit irq
// - Input data read clears flag, sends ack
// - Ready rises after send and ack
// - Select and direction choose register
// - Write data taken at chip select rise
// - Input data holds only received bytes
module lasp_port
  import lasp_pkg::*;
(
  input wire logic ref_clk, // Device clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic chip_select_n, // Chip select, active low.
  input wire logic read_not_write_line, // High reads, low writes.
  input wire logic [1:0] reg_select, // Register select.
  input wire logic [7:0] host_data_in, // Data bus as seen on the pins.
  output logic [7:0] host_data_out, // Data bus value driven on reads.
  output logic host_data_oe_n, // Low while the port drives the bus.
  input wire logic rx_byte_valid, // Pulse: a data byte arrived.
  input wire logic [7:0] rx_byte_data, // Received byte.
  input wire logic rx_ack_seen, // Pulse: acknowledge arrived.
  input wire logic tx_done, // Pulse: data byte fully sent.
  output lasp_byte_s tx_byte, // Byte to send, valid for one cycle.
  output logic tx_ack_req, // Pulse: send an acknowledge.
  output logic rx_irq_out, // Receive interrupt.
  output logic tx_irq_out // Transmit interrupt.
);

  // Access phase and latched selection.
  // Select and direction are held from the start of an access, so the host
  // may change them before chip select returns high.
  lasp_phase_e phase_reg, phase_next; // Idle or inside an access.
  logic [1:0] sel_reg, sel_next; // Register chosen at access start.
  logic rnw_reg, rnw_next; // Direction chosen at access start.
  // Flags and enables.
  logic dpres_reg, dpres_next; // Data present flag.
  logic ien_in_reg, ien_in_next; // Receive interrupt enable.
  logic ien_out_reg, ien_out_next; // Transmit interrupt enable.
  logic oready_reg, oready_next; // Output ready flag.
  logic sent_reg, sent_next; // Byte has left the transmitter.
  logic acked_reg, acked_next; // Acknowledge arrived since the write.
  // Data held for the host and for the link.
  logic [7:0] in_data_reg, in_data_next; // Last received data byte.
  logic [7:0] rd_reg, rd_next; // Read data shown on the bus.
  lasp_byte_s tx_reg, tx_next; // Byte handed to the transmitter.
  logic ack_reg, ack_next; // Acknowledge request pulse.
  // Access end events, each high for the one cycle that ends an access.
  logic cs_rise; // Chip select seen high again inside an access.
  logic rd_in_data; // Host read of the input data register.
  logic wr_out_data; // Host write of the output data register.
  logic wr_in_stat; // Host write of the input status register.
  logic wr_out_stat; // Host write of the output status register.

  // End of access is the rising edge of chip select.
  // The write data bus is sampled on this same cycle, never earlier.
  always_comb begin
    cs_rise = (phase_reg == LASP_ACCESS) && chip_select_n;
    rd_in_data = cs_rise && rnw_reg && (sel_reg == `LASP_SEL_DATA);
    wr_out_data = cs_rise && !rnw_reg && (sel_reg == `LASP_SEL_OUT_DATA);
    wr_in_stat = cs_rise && !rnw_reg && (sel_reg == `LASP_SEL_IN_STAT);
    wr_out_stat = cs_rise && !rnw_reg && (sel_reg == `LASP_SEL_OUT_STAT);
  end

  // Access phase: latch select and direction when chip select falls.
  // A chip select held low keeps one access open however long it lasts.
  always_comb begin
    phase_next = phase_reg;
    sel_next = sel_reg;
    rnw_next = rnw_reg;
    unique case (phase_reg)
      // Waiting for the host to select the port.
      LASP_IDLE: begin
        if (!chip_select_n) begin
          // Chip select fell: the access starts and its selection is latched.
          phase_next = LASP_ACCESS;
          sel_next = reg_select;
          rnw_next = read_not_write_line;
        end
      end
      // Inside an access until chip select returns high.
      LASP_ACCESS: begin
        if (chip_select_n) begin
          // Chip select rose: the access ends on this cycle.
          phase_next = LASP_IDLE;
        end
      end
    endcase
  end

  // Read data mux, built on entry to the access.
  // The value stays put for the whole access, so the bus never glitches.
  always_comb begin
    rd_next = rd_reg;
    if (phase_reg == LASP_IDLE && !chip_select_n) begin
      // Chip select just fell: pick the register being read.
      unique case (reg_select)
        // Input data: the last received byte.
        `LASP_SEL_DATA: rd_next = in_data_reg;
        // Output data is write only and reads a fixed value.
        `LASP_SEL_OUT_DATA: rd_next = `LASP_UNDEF_READ;
        // Input status: enable above flag, unused bits zero.
        `LASP_SEL_IN_STAT: rd_next = {6'h00, ien_in_reg, dpres_reg};
        // Output status: enable above flag, unused bits zero.
        `LASP_SEL_OUT_STAT: rd_next = {6'h00, ien_out_reg, oready_reg};
      endcase
    end
  end

  // Input side: received bytes and the data present flag.
  // A byte arriving on the cycle of a read is kept, so none is lost.
  always_comb begin
    dpres_next = dpres_reg;
    in_data_next = in_data_reg;
    ack_next = 1'b0;
    ien_in_next = ien_in_reg;
    // The host took the byte: free the buffer and acknowledge it.
    if (rd_in_data) begin
      dpres_next = 1'b0;
      ack_next = 1'b1;
    end
    // A new byte from the link fills the buffer.
    if (rx_byte_valid) begin
      dpres_next = 1'b1; // set wins over a same-cycle read.
      in_data_next = rx_byte_data;
    end
    // Status writes change only the enable bit.
    if (wr_in_stat) begin
      ien_in_next = host_data_in[`LASP_IEN_BIT];
    end
  end

  // Output side: send on write, ready after send and acknowledge.
  // Done and acknowledge may come in either order; both are remembered.
  always_comb begin
    oready_next = oready_reg;
    sent_next = sent_reg || tx_done;
    acked_next = acked_reg || rx_ack_seen;
    tx_next = '{valid: 1'b0, data: tx_reg.data};
    ien_out_next = ien_out_reg;
    // Both halves of the transfer are over: the buffer is free again.
    if (!oready_reg && sent_next && acked_next) begin
      oready_next = 1'b1;
    end
    // A new byte starts a transfer and wins over a late done or acknowledge.
    if (wr_out_data) begin
      oready_next = 1'b0;
      sent_next = 1'b0;
      acked_next = 1'b0;
      tx_next = '{valid: 1'b1, data: host_data_in};
    end
    // Status writes change only the enable bit.
    if (wr_out_stat) begin
      ien_out_next = host_data_in[`LASP_IEN_BIT];
    end
  end

  // All state registers.
  // Reset leaves the port idle, the output free and both enables off.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Only constants here, so reset does not depend on any input.
      phase_reg <= LASP_IDLE;
      sel_reg <= 2'h0;
      rnw_reg <= 1'b1;
      dpres_reg <= `LASP_DPRES_RST;
      ien_in_reg <= `LASP_IEN_RST;
      ien_out_reg <= `LASP_IEN_RST;
      oready_reg <= `LASP_OREADY_RST;
      sent_reg <= 1'b1;
      acked_reg <= 1'b1;
      in_data_reg <= 8'h00;
      rd_reg <= 8'h00;
      tx_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      // Every register takes its next value on every edge.
      phase_reg <= phase_next;
      sel_reg <= sel_next;
      rnw_reg <= rnw_next;
      dpres_reg <= dpres_next;
      ien_in_reg <= ien_in_next;
      ien_out_reg <= ien_out_next;
      oready_reg <= oready_next;
      sent_reg <= sent_next;
      acked_reg <= acked_next;
      in_data_reg <= in_data_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      ack_reg <= ack_next;
    end
  end

  // Outputs: interrupts are the AND of enable and flag.
  // Both come from registers, so they cannot glitch on bus activity.
  assign rx_irq_out = ien_in_reg && dpres_reg;
  assign tx_irq_out = ien_out_reg && oready_reg;
  assign tx_byte = tx_reg;
  assign tx_ack_req = ack_reg;
  assign host_data_out = rd_reg;
  // The bus is driven only during a selected read access.
  // It is released as soon as chip select rises, before the next access.
  assign host_data_oe_n = !(phase_reg == LASP_ACCESS && rnw_reg && !chip_select_n);

  // Checks.
  // Each property except a_bus_released and a_status_pad watches ports or registers one edge after the event that
  // should move them, so that it does not restate the logic it guards.
  // A received byte raises the receive interrupt while it is enabled.
  a_rx_irq_and: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_byte_valid && ien_in_reg && !wr_in_stat |=> rx_irq_out)
    else $error("receive irq mismatch");
  // Enabling the transmit interrupt while ready raises it.
  a_tx_irq_and: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_out_stat && host_data_in[`LASP_IEN_BIT] && oready_reg |=> tx_irq_out)
    else $error("transmit irq mismatch");
  // An input data read clears the flag and requests an acknowledge.
  a_read_clears_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_in_data && !rx_byte_valid |=> !dpres_reg && tx_ack_req)
    else $error("input read did not clear flag and ack");
  // A received byte is held and flagged.
  a_rx_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_byte_valid |=> dpres_reg && in_data_reg == $past(rx_byte_data))
    else $error("received byte not held");
  // Data present falls only after an input data read.
  a_flag_only_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(dpres_reg) |-> $past(rd_in_data))
    else $error("data present fell without read");
  // An output data write hands the byte to the link and drops ready.
  a_write_sends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_out_data |=> tx_byte.valid && tx_byte.data == $past(host_data_in) && !oready_reg)
    else $error("output write not sent");
  // Ready falls only after an output data write.
  a_ready_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(oready_reg) |-> $past(wr_out_data))
    else $error("ready fell without write");
  // Ready rises only on the edge after a send done or an acknowledge.
  a_ready_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(oready_reg) |-> $past(tx_done || rx_ack_seen))
    else $error("ready rose early");
  // The input enable takes the written bit.
  a_ien_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_in_stat |=> ien_in_reg == $past(host_data_in[`LASP_IEN_BIT]))
    else $error("enable not written");
  // Reading output data sends nothing on the link.
  a_odata_read_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cs_rise && rnw_reg && sel_reg == `LASP_SEL_OUT_DATA |=> !tx_byte.valid && !tx_ack_req)
    else $error("output data read had an effect");
  // The output enable takes the written bit.
  a_tx_ien_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_out_stat |=> ien_out_reg == $past(host_data_in[`LASP_IEN_BIT]))
    else $error("output enable not written");
  // An input data read lowers the receive interrupt.
  a_rx_irq_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_in_data && !rx_byte_valid |=> !rx_irq_out)
    else $error("receive irq stayed high after read");
  // An output data write lowers the transmit interrupt.
  a_tx_irq_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_out_data |=> !tx_irq_out)
    else $error("transmit irq stayed high after write");
  // A host write to the input data register changes nothing.
  a_in_data_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cs_rise && !rnw_reg && sel_reg == `LASP_SEL_DATA && !rx_byte_valid
      |=> $stable(in_data_reg) && !$rose(dpres_reg))
    else $error("input data write had an effect");
  // The bus is not driven outside a selected read.
  a_bus_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
    chip_select_n || !rnw_reg |-> host_data_oe_n)
    else $error("bus driven outside a read");
  // Status reads show zero in the unused bits.
  a_status_pad: assert property (@(posedge ref_clk) disable iff (!rst_b)
    phase_reg == LASP_ACCESS && rnw_reg && sel_reg[1] |-> host_data_out[7:2] == 6'h00)
    else $error("status unused bits not zero");
  // One read asks for exactly one acknowledge.
  a_ack_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tx_ack_req |=> !tx_ack_req)
    else $error("acknowledge request longer than one cycle");
  // One write hands over exactly one byte.
  a_tx_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tx_byte.valid |=> !tx_byte.valid)
    else $error("byte valid longer than one cycle");
  // Cover points for the main scenarios.
  c_rx_read: cover property (@(posedge ref_clk) disable iff (!rst_b) rd_in_data);
  c_tx_write: cover property (@(posedge ref_clk) disable iff (!rst_b) wr_out_data);
  c_ready_back: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(oready_reg));
  c_rx_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(rx_irq_out));
  c_tx_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(tx_irq_out));

endmodule // lasp_port
`default_nettype wire

// >>> common/lasp_cfg.svh
// Constants for the link adaptor bus status port.
// Assumes inclusion by the design module only.
`ifndef LASP_CFG_SVH
`define LASP_CFG_SVH
`define LASP_SEL_DATA 2'h0
`define LASP_SEL_OUT_DATA 2'h1
`define LASP_SEL_IN_STAT 2'h2
`define LASP_SEL_OUT_STAT 2'h3
`define LASP_FLAG_BIT 0
`define LASP_IEN_BIT 1
`define LASP_IEN_RST 1'h0
`define LASP_OREADY_RST 1'h1
`define LASP_DPRES_RST 1'h0
`define LASP_UNDEF_READ 8'h00
`endif

// >>> common/lasp_pkg.sv
// Types for the link adaptor bus status port.
// Assumes the constants header is available on the include path.
`default_nettype none
package lasp_pkg;
  // One byte handed between the port and the link transmitter.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lasp_byte_s;
  // Phase of one chip-select access.
  typedef enum logic {LASP_IDLE, LASP_ACCESS} lasp_phase_e;
endpackage
`default_nettype wire

// >>> verification/lasp_link_model.sv
// Link-side model: finishes each sent byte, then returns an acknowledge.
// Assumes the port's one-cycle pulses are sampled on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module lasp_link_model
  import lasp_pkg::*;
#(parameter int DLY = 12)
(
  input wire logic ref_clk, // Device clock.
  input wire logic rst_b, // Reset, active low.
  input wire lasp_byte_s tx_byte, // Byte to send.
  input wire logic tx_ack_req, // Request to send an acknowledge.
  output logic tx_done, // Pulse: byte sent.
  output logic rx_ack_seen, // Pulse: acknowledge returned.
  output logic [7:0] last_byte, // Last byte sent.
  output int n_ack // Acknowledges sent.
);
  int cnt_reg; // Cycles left until the byte and its acknowledge finish.
  // Done comes first and the acknowledge a cycle later, a slow link.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 0;
      tx_done <= 1'b0;
      rx_ack_seen <= 1'b0;
      last_byte <= 8'h00;
      n_ack <= 0;
    end else begin
      tx_done <= (cnt_reg == 2);
      rx_ack_seen <= (cnt_reg == 1);
      if (tx_byte.valid) begin
        last_byte <= tx_byte.data;
        cnt_reg <= DLY;
      end else if (cnt_reg != 0) begin
        cnt_reg <= cnt_reg - 1;
      end
      if (tx_ack_req) begin
        n_ack <= n_ack + 1;
      end
    end
  end
endmodule // lasp_link_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the link adaptor bus status port.
// Assumes the link model answers every byte written for sending.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lasp_pkg::*;
  logic ref_clk = 1'b0; // Device clock.
  logic rst_b = 1'b0; // Reset, active low.
  logic cs_n = 1'b1; // Chip select, active low.
  logic rnw = 1'b1; // Read when high.
  logic rxv = 1'b0; // Received byte pulse.
  logic [1:0] sel = 2'h0; // Register select.
  logic [7:0] din = 8'h00; // Write data.
  logic [7:0] rxd = 8'h00; // Received byte.
  logic [7:0] dout, rd, last; // Read data and last sent byte.
  logic oe_n, done, ack, ackr, rxi, txi; // Port and model outputs.
  lasp_byte_s txb; // Byte leaving for the link.
  int n_fail = 0; // Mismatches.
  int comparisons = 0; // Comparisons made.
  int n_ack; // Acknowledges sent.
  int i; // Poll counter.
  always #5 ref_clk = ~ref_clk;
  lasp_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_n(cs_n),
    .read_not_write_line(rnw), .reg_select(sel), .host_data_in(din), .host_data_out(dout),
    .host_data_oe_n(oe_n), .rx_byte_valid(rxv), .rx_byte_data(rxd), .rx_ack_seen(ack),
    .tx_done(done), .tx_byte(txb), .tx_ack_req(ackr), .rx_irq_out(rxi), .tx_irq_out(txi));
  lasp_link_model link (.ref_clk(ref_clk), .rst_b(rst_b), .tx_byte(txb), .tx_ack_req(ackr),
    .tx_done(done), .rx_ack_seen(ack), .last_byte(last), .n_ack(n_ack));
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One access; select, direction and data stay steady while selected.
  task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    rnw <= r;
    sel <= s;
    din <= d;
    repeat (3) @(posedge ref_clk);
    rd = dout;
    if (r) chk({7'h00, oe_n}, 8'h00);
    else chk({7'h00, oe_n}, 8'h01);
    cs_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk({6'h00, rxi, txi}, 8'h00);
    chk({7'h00, oe_n}, 8'h01);
    acc(1'b1, 2'h3, 8'h00);
    chk(rd, 8'h01);
    acc(1'b1, 2'h2, 8'h00);
    chk(rd, 8'h00);
    acc(1'b0, 2'h3, 8'h02);
    chk({7'h00, txi}, 8'h01);
    acc(1'b0, 2'h1, 8'h5a);
    chk({7'h00, txi}, 8'h00);
    acc(1'b1, 2'h3, 8'h00);
    chk(rd, 8'h02);
    for (i = 0; i < 40 && rd !== 8'h03; i++) acc(1'b1, 2'h3, 8'h00);
    if (rd !== 8'h03) begin
      n_fail++;
      finish_test();
    end
    chk(last, 8'h5a);
    chk({7'h00, txi}, 8'h01);
    acc(1'b0, 2'h3, 8'h00);
    chk({7'h00, txi}, 8'h00);
    acc(1'b1, 2'h1, 8'h00);
    chk(rd, 8'h00);
    acc(1'b0, 2'h3, 8'h02);
    chk({7'h00, txi}, 8'h01);
    acc(1'b0, 2'h0, 8'hff);
    acc(1'b0, 2'h2, 8'h02);
    acc(1'b1, 2'h2, 8'h00);
    chk(rd, 8'h02);
    @(posedge ref_clk);
    rxv <= 1'b1;
    rxd <= 8'hc3;
    @(posedge ref_clk);
    rxv <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({7'h00, rxi}, 8'h01);
    acc(1'b1, 2'h2, 8'h00);
    chk(rd, 8'h03);
    acc(1'b0, 2'h2, 8'h00);
    chk({7'h00, rxi}, 8'h00);
    acc(1'b0, 2'h2, 8'h02);
    chk({7'h00, rxi}, 8'h01);
    acc(1'b1, 2'h0, 8'h00);
    chk(rd, 8'hc3);
    chk({7'h00, rxi}, 8'h00);
    chk(n_ack[7:0], 8'h01);
    acc(1'b1, 2'h2, 8'h00);
    chk(rd, 8'h02);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
